// File: core/bst_pkg.sv
// Constants and types of the boundary-scan test access block.
package bst_pkg;
   // ----------------------------------------
   // Instruction codes
   // ----------------------------------------
   localparam int IR_W = 4;
   localparam logic [3:0] IR_EXTEST = 4'h0;
   localparam logic [3:0] IR_SAMPLE = 4'h1;
   localparam logic [3:0] IR_PRELOAD = 4'h2;
   localparam logic [3:0] IR_IDCODE = 4'h3;
   localparam logic [3:0] IR_HIGHZ = 4'h4;
   localparam logic [3:0] IR_CLAMP = 4'h5;
   localparam logic [3:0] IR_BYPASS = 4'hf;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int GPIO_W = 5;
   localparam int BSR_W = 8;
   localparam int DR_W = 32;
   localparam logic [4:0] DR_LAST = 5'h1f;
   // Arbitrary identification code value.
   localparam logic [31:0] IDCODE_VAL = 32'h1234_5679;
   // GPIO lane positions of the scan port.
   localparam int P_TCK = 0;
   localparam int P_TMS = 1;
   localparam int P_TDI = 2;
   localparam int P_TDO = 3;
   localparam int P_TRST = 4;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h3, S_CAP_DR = 4'h2,
      S_SH_DR = 4'h6, S_EX1_DR = 4'h7, S_PAU_DR = 4'h5, S_EX2_DR = 4'h4,
      S_UPD_DR = 4'hc, S_SEL_IR = 4'hd, S_CAP_IR = 4'hf, S_SH_IR = 4'he,
      S_EX1_IR = 4'ha, S_PAU_IR = 4'hb, S_EX2_IR = 4'h9, S_UPD_IR = 4'h8
   } bst_state_e;
   typedef struct packed {
      logic [4:0] out;
      logic [4:0] oe_n;
   } bst_pins_s;
endpackage

// File: core/bst_tap.sv
// Boundary-scan test access port sharing five GPIO pins.
// Contract
// RQ1 - Test-select low turns the five shared GPIO pins into scan port signals.
// RQ2 - Test-select low stops normal operation; only scan access remains.
// RQ3 - GPIO0..4 carry TCK, TMS, TDI, TDO, TRSTn in test mode.
// RQ4 - Standard TAP with IDCODE, BYPASS, EXTEST, SAMPLE, PRELOAD, HIGHZ, CLAMP.
// RQ5 - IDCODE instruction shifts the fixed identification code out on TDO.
// RQ6 - Controller should pulse master reset when it releases test-select.
// RQ7 - TAP controller held in Test-Logic-Reset while test-select is high.
`timescale 1ns/1ns
`default_nettype none
module bst_tap (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_scan_mode_select_n,
   input wire logic [4:0] i_gpio,
   output logic [4:0] o_gpio,
   output logic [4:0] o_gpio_oe_n,
   input wire logic [4:0] i_core_gpio_out,
   input wire logic [4:0] i_core_gpio_oe_n,
   output logic [4:0] o_core_gpio_in,
   input wire logic [7:0] i_core_pins,
   input wire logic [7:0] i_core_pins_oe_n,
   output logic [7:0] o_pins,
   output logic [7:0] o_pins_oe_n,
   output logic o_operational
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [5:0] sy1_q;
   logic [5:0] sy2_q;
   logic tck_prev_q;
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         sy1_q <= 6'h3f;
         sy2_q <= 6'h3f;
         tck_prev_q <= 1'b0;
      end else begin
         sy1_q <= {i_scan_mode_select_n, i_gpio};
         sy2_q <= sy1_q;
         tck_prev_q <= sy2_q[bst_pkg::P_TCK];
      end
   end
   wire test_mode = ~sy2_q[5];
   wire tck = sy2_q[bst_pkg::P_TCK];
   wire tms = sy2_q[bst_pkg::P_TMS];
   wire tdi = sy2_q[bst_pkg::P_TDI];
   wire trst_n = sy2_q[bst_pkg::P_TRST];
   wire tck_rise = test_mode & tck & ~tck_prev_q;
   wire tck_fall = test_mode & ~tck & tck_prev_q;
   // Asynchronous-style hold: reset, trst or normal mode keep the TAP in reset.
   wire tap_clr = i_sys_rst | ~test_mode | ~trst_n; // RQ7
   // ----------------------------------------
   // TAP controller
   // ----------------------------------------
   bst_pkg::bst_state_e st_q;
   bst_pkg::bst_state_e st_d;
   always_comb begin
      st_d = st_q;
      case (st_q)
         bst_pkg::S_RESET: st_d = tms ? bst_pkg::S_RESET : bst_pkg::S_IDLE;
         bst_pkg::S_IDLE: st_d = tms ? bst_pkg::S_SEL_DR : bst_pkg::S_IDLE;
         bst_pkg::S_SEL_DR: st_d = tms ? bst_pkg::S_SEL_IR : bst_pkg::S_CAP_DR;
         bst_pkg::S_CAP_DR: st_d = tms ? bst_pkg::S_EX1_DR : bst_pkg::S_SH_DR;
         bst_pkg::S_SH_DR: st_d = tms ? bst_pkg::S_EX1_DR : bst_pkg::S_SH_DR;
         bst_pkg::S_EX1_DR: st_d = tms ? bst_pkg::S_UPD_DR : bst_pkg::S_PAU_DR;
         bst_pkg::S_PAU_DR: st_d = tms ? bst_pkg::S_EX2_DR : bst_pkg::S_PAU_DR;
         bst_pkg::S_EX2_DR: st_d = tms ? bst_pkg::S_UPD_DR : bst_pkg::S_SH_DR;
         bst_pkg::S_UPD_DR: st_d = tms ? bst_pkg::S_SEL_DR : bst_pkg::S_IDLE;
         bst_pkg::S_SEL_IR: st_d = tms ? bst_pkg::S_RESET : bst_pkg::S_CAP_IR;
         bst_pkg::S_CAP_IR: st_d = tms ? bst_pkg::S_EX1_IR : bst_pkg::S_SH_IR;
         bst_pkg::S_SH_IR: st_d = tms ? bst_pkg::S_EX1_IR : bst_pkg::S_SH_IR;
         bst_pkg::S_EX1_IR: st_d = tms ? bst_pkg::S_UPD_IR : bst_pkg::S_PAU_IR;
         bst_pkg::S_PAU_IR: st_d = tms ? bst_pkg::S_EX2_IR : bst_pkg::S_PAU_IR;
         bst_pkg::S_EX2_IR: st_d = tms ? bst_pkg::S_UPD_IR : bst_pkg::S_SH_IR;
         bst_pkg::S_UPD_IR: st_d = tms ? bst_pkg::S_SEL_DR : bst_pkg::S_IDLE;
         default: st_d = bst_pkg::S_RESET;
      endcase
   end
   // ----------------------------------------
   // Instruction and data registers
   // ----------------------------------------
   logic [3:0] ir_q;
   logic [3:0] ir_sh_q;
   logic [31:0] dr_q;
   logic [7:0] bsr_q;
   logic tdo_q;
   logic tdo_en_q;
   wire sel_id = (ir_q == bst_pkg::IR_IDCODE); // RQ4
   wire sel_bsr = (ir_q == bst_pkg::IR_EXTEST) | (ir_q == bst_pkg::IR_SAMPLE)
      | (ir_q == bst_pkg::IR_PRELOAD);
   wire [31:0] dr_shift = sel_id ? {tdi, dr_q[31:1]}
      : sel_bsr ? {24'h000000, tdi, dr_q[7:1]} : {31'h00000000, tdi};
   wire [31:0] dr_cap = sel_id ? bst_pkg::IDCODE_VAL // RQ5
      : sel_bsr ? {24'h000000, i_core_pins} : 32'h00000000;
   always_ff @(posedge i_clk_sys) begin
      if (tap_clr) begin
         st_q <= bst_pkg::S_RESET;
         ir_q <= bst_pkg::IR_IDCODE;
         ir_sh_q <= 4'h0;
         dr_q <= 32'h00000000;
         bsr_q <= 8'h00;
      end else if (tck_rise) begin
         st_q <= st_d; // RQ4
         if (st_q == bst_pkg::S_CAP_IR) ir_sh_q <= bst_pkg::IR_CAPTURE;
         if (st_q == bst_pkg::S_SH_IR) ir_sh_q <= {tdi, ir_sh_q[3:1]};
         if (st_q == bst_pkg::S_CAP_DR) dr_q <= dr_cap;
         if (st_q == bst_pkg::S_SH_DR) dr_q <= dr_shift;
         if (st_q == bst_pkg::S_RESET) ir_q <= bst_pkg::IR_IDCODE;
         if (st_q == bst_pkg::S_UPD_IR) ir_q <= ir_sh_q;
         if (st_q == bst_pkg::S_UPD_DR && sel_bsr && ir_q != bst_pkg::IR_SAMPLE)
            bsr_q <= dr_q[7:0];
      end
   end
   // Shift-IR and Shift-DR are the only states in which TDO carries data.
   function automatic logic in_shift(input bst_pkg::bst_state_e st);
      in_shift = (st == bst_pkg::S_SH_IR) | (st == bst_pkg::S_SH_DR);
   endfunction
   // TDO changes on the falling edge of TCK.
   always_ff @(posedge i_clk_sys) begin
      if (tap_clr) begin
         tdo_q <= 1'b0;
         tdo_en_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_q <= (st_q == bst_pkg::S_SH_IR) ? ir_sh_q[0] : dr_q[0];
         tdo_en_q <= in_shift(st_q); // RQ3
      end
   end
   // ----------------------------------------
   // Pin multiplexing
   // ----------------------------------------
   wire drive_bsr = test_mode & ((ir_q == bst_pkg::IR_EXTEST) | (ir_q == bst_pkg::IR_CLAMP));
   wire high_z = test_mode & (ir_q == bst_pkg::IR_HIGHZ);
   bst_pkg::bst_pins_s gp;
   assign gp.out = test_mode ? {1'b0, tdo_q, 3'h0} : i_core_gpio_out; // RQ3
   assign gp.oe_n = test_mode ? {1'b1, ~tdo_en_q, 3'h7} : i_core_gpio_oe_n; // RQ1
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_gpio <= 5'h00;
         o_gpio_oe_n <= 5'h1f;
         o_pins <= 8'h00;
         o_pins_oe_n <= 8'hff;
         o_core_gpio_in <= 5'h00;
         o_operational <= 1'b0;
      end else begin
         o_gpio <= gp.out;
         o_gpio_oe_n <= gp.oe_n;
         o_pins <= drive_bsr ? bsr_q : i_core_pins;
         o_pins_oe_n <= high_z ? 8'hff : (drive_bsr ? 8'h00 : i_core_pins_oe_n);
         o_core_gpio_in <= test_mode ? 5'h00 : sy2_q[4:0]; // RQ1
         o_operational <= ~test_mode; // RQ2
      end
   end
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_hold_reset;
      @(posedge i_clk_sys) disable iff (i_sys_rst) !test_mode |=> st_q == bst_pkg::S_RESET;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("TAP left reset in normal mode"); // RQ7
   property p_nonop;
      @(posedge i_clk_sys) disable iff (i_sys_rst) test_mode |=> !o_operational;
   endproperty
   a_nonop: assert property (p_nonop) else $error("device operational in test mode"); // RQ2
   property p_op;
      @(posedge i_clk_sys) disable iff (i_sys_rst) !test_mode |=> o_operational;
   endproperty
   a_op: assert property (p_op) else $error("device not operational in normal mode"); // RQ2
   property p_inputs_only;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
         test_mode |=> o_gpio_oe_n[2:0] == 3'h7 && o_gpio_oe_n[4];
   endproperty
   a_inputs_only: assert property (p_inputs_only) else $error("scan input pin driven"); // RQ3
   property p_gpio_pass;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
         !test_mode |=> o_gpio_oe_n == $past(i_core_gpio_oe_n);
   endproperty
   a_gpio_pass: assert property (p_gpio_pass) else $error("GPIO enable not passed"); // RQ1
   property p_core_blind;
      @(posedge i_clk_sys) disable iff (i_sys_rst) test_mode |=> o_core_gpio_in == 5'h00;
   endproperty
   a_core_blind: assert property (p_core_blind) else $error("core sees scan pins"); // RQ1
   property p_id_cap;
      @(posedge i_clk_sys) disable iff (tap_clr)
         tck_rise && st_q == bst_pkg::S_CAP_DR && sel_id |=> dr_q == bst_pkg::IDCODE_VAL;
   endproperty
   a_id_cap: assert property (p_id_cap) else $error("IDCODE not captured"); // RQ5
   property p_highz;
      @(posedge i_clk_sys) disable iff (i_sys_rst) high_z |=> o_pins_oe_n == 8'hff;
   endproperty
   a_highz: assert property (p_highz) else $error("HIGHZ pins driven"); // RQ4
   property p_reset_ir;
      @(posedge i_clk_sys) disable iff (tap_clr)
         tck_rise && st_q == bst_pkg::S_RESET |=> ir_q == bst_pkg::IR_IDCODE;
   endproperty
   a_reset_ir: assert property (p_reset_ir) else $error("IR not IDCODE after reset"); // RQ4
   property p_tdo_quiet;
      @(posedge i_clk_sys) disable iff (i_sys_rst) test_mode && !tdo_en_q |=> o_gpio_oe_n[3];
   endproperty
   a_tdo_quiet: assert property (p_tdo_quiet) else $error("TDO driven outside shift"); // RQ3
   property p_bsr_drive;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
         test_mode && (ir_q == bst_pkg::IR_EXTEST || ir_q == bst_pkg::IR_CLAMP)
         |=> o_pins == $past(bsr_q) && o_pins_oe_n == 8'h00;
   endproperty
   a_bsr_drive: assert property (p_bsr_drive) else $error("boundary cells not on pins"); // RQ4
   property p_sample_pass;
      @(posedge i_clk_sys) disable iff (i_sys_rst)
         test_mode && ir_q == bst_pkg::IR_SAMPLE |=> o_pins == $past(i_core_pins);
   endproperty
   a_sample_pass: assert property (p_sample_pass) else $error("SAMPLE disturbed the pins"); // RQ4
   property p_ir_cap;
      @(posedge i_clk_sys) disable iff (tap_clr)
         tck_rise && st_q == bst_pkg::S_CAP_IR |=> ir_sh_q == bst_pkg::IR_CAPTURE;
   endproperty
   a_ir_cap: assert property (p_ir_cap) else $error("IR capture pattern wrong"); // RQ4
   property p_bypass_cap;
      @(posedge i_clk_sys) disable iff (tap_clr)
         tck_rise && st_q == bst_pkg::S_CAP_DR && !sel_id && !sel_bsr |=> dr_q[0] == 1'b0;
   endproperty
   a_bypass_cap: assert property (p_bypass_cap) else $error("bypass bit not cleared"); // RQ4
endmodule
`default_nettype wire

// File: test/bst_ctl_model.sv
// Scan controller model that drives the shared pins in test mode.
`timescale 1ns/1ns
`default_nettype none
module bst_ctl_model (
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   output logic o_trst_n,
   input wire logic i_tdo
);
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
      o_trst_n = 1'b1;
   end
   // One 64 ns TCK period; TMS and TDI change at the fall, TDO is taken late in the high half.
   task automatic bit_cyc(input logic tms, input logic tdi, output logic tdo);
      o_tck = 1'b0;
      o_tms = tms;
      o_tdi = tdi;
      #32 o_tck = 1'b1;
      #28 tdo = i_tdo;
      #4;
   endtask
   // From Test-Logic-Reset or Idle through one IR or DR scan and back to Idle.
   task automatic shift(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
      logic t;
      dout = 32'h0;
      #3 bit_cyc(1'b0, 1'b0, t);
      bit_cyc(1'b1, 1'b0, t);
      if (ir) bit_cyc(1'b1, 1'b0, t);
      bit_cyc(1'b0, 1'b0, t);
      bit_cyc(1'b0, 1'b0, t);
      for (int i = 0; i < n; i++) begin
         bit_cyc(i == n - 1, din[i], t);
         dout[i] = t;
      end
      bit_cyc(1'b1, 1'b0, t);
      bit_cyc(1'b0, 1'b0, t);
      o_tck = 1'b0;
      #64;
   endtask
   task automatic trst_pulse;
      o_trst_n = 1'b0;
      #200 o_trst_n = 1'b1;
      #64;
   endtask
endmodule
`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench of the boundary-scan access block.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_sys_rst = 1'b1;
   logic sel_n = 1'b1;
   logic [4:0] c_out = 5'h00;
   logic [4:0] c_oe_n = 5'h1f;
   logic [7:0] c_pins = 8'h00;
   logic [7:0] c_pins_oe_n = 8'hff;
   logic tdo_last = 1'b0;
   logic [31:0] rd;
   wire logic [4:0] g_o, g_oe_n, c_in;
   wire logic [7:0] pins, pins_oe_n;
   wire logic oper, tck, tms, tdi, trst_n;
   wire logic tdo_pad = g_oe_n[3] ? ~tdo_last : g_o[3];
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   always #4 i_clk_sys = ~i_clk_sys;
   bst_tap dut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_scan_mode_select_n(sel_n),
      .i_gpio({trst_n, tdo_pad, tdi, tms, tck}), .o_gpio(g_o), .o_gpio_oe_n(g_oe_n),
      .i_core_gpio_out(c_out), .i_core_gpio_oe_n(c_oe_n), .o_core_gpio_in(c_in),
      .i_core_pins(c_pins), .i_core_pins_oe_n(c_pins_oe_n), .o_pins(pins),
      .o_pins_oe_n(pins_oe_n), .o_operational(oper));
   bst_ctl_model u_ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n),
      .i_tdo(tdo_pad));
   task automatic tally_and_finish;
      $display("compares=%0d bad_count=%0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (!g_oe_n[3]) tdo_last <= g_o[3];
      if (cyc == 30000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ir(input logic [3:0] code);
      u_ctl.shift(1'b1, bst_pkg::IR_W, {28'h0, code}, rd);
      chk(rd[3:0], bst_pkg::IR_CAPTURE);
   endtask
   task automatic t_normal;
      @(negedge i_clk_sys) c_oe_n = 5'h00;
      c_out = 5'h15;
      c_pins = 8'ha5;
      c_pins_oe_n = 8'h5a;
      repeat (6) @(negedge i_clk_sys);
      chk(oper, 1'b1);
      chk(g_o, 5'h15);
      chk(g_oe_n, 5'h00);
      chk(pins, 8'ha5);
      chk(pins_oe_n, 8'h5a);
      c_oe_n = 5'h1f;
      repeat (6) @(negedge i_clk_sys);
      chk({c_in[4], c_in[2:0]}, 4'ha);
      u_ctl.shift(1'b1, 4, 32'hf, rd);
      chk(c_in, 5'h18);
   endtask
   task automatic t_enter;
      @(negedge i_clk_sys) sel_n = 1'b0;
      repeat (6) @(negedge i_clk_sys);
      chk(oper, 1'b0);
      chk(c_in, 5'h00);
      chk(g_oe_n, 5'h1f);
      u_ctl.shift(1'b0, 32, 32'h0, rd);
      chk(rd, bst_pkg::IDCODE_VAL);
   endtask
   task automatic t_bypass;
      ir(bst_pkg::IR_BYPASS);
      u_ctl.shift(1'b0, 8, 32'h5a, rd);
      chk(rd[7:0], 8'hb4);
   endtask
   task automatic t_bsr;
      @(negedge i_clk_sys) c_pins = 8'h3c;
      ir(bst_pkg::IR_SAMPLE);
      chk(pins, 8'h3c);
      u_ctl.shift(1'b0, 8, 32'hc3, rd);
      chk(rd[7:0], 8'h3c);
      ir(bst_pkg::IR_PRELOAD);
      u_ctl.shift(1'b0, 8, 32'h96, rd);
      chk(rd[7:0], 8'h3c);
      chk(pins, 8'h3c);
      ir(bst_pkg::IR_EXTEST);
      chk(pins, 8'h96);
      chk(pins_oe_n, 8'h00);
      ir(bst_pkg::IR_HIGHZ);
      chk(pins_oe_n, 8'hff);
      ir(bst_pkg::IR_CLAMP);
      chk(pins, 8'h96);
      chk(pins_oe_n, 8'h00);
      u_ctl.shift(1'b0, 2, 32'h1, rd);
      chk(rd[1:0], 2'h2);
   endtask
   task automatic t_trst;
      ir(bst_pkg::IR_BYPASS);
      u_ctl.trst_pulse();
      u_ctl.shift(1'b0, 32, 32'h0, rd);
      chk(rd, bst_pkg::IDCODE_VAL);
   endtask
   task automatic t_exit;
      @(negedge i_clk_sys) sel_n = 1'b1;
      i_sys_rst = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      i_sys_rst = 1'b0;
      repeat (8) @(negedge i_clk_sys);
      chk(oper, 1'b1);
      chk(g_oe_n, c_oe_n);
      chk(pins, 8'h3c);
      chk(pins_oe_n, 8'h5a);
   endtask
   initial begin
      repeat (20) @(negedge i_clk_sys);
      i_sys_rst = 1'b0;
      repeat (6) @(negedge i_clk_sys);
      t_normal();
      t_enter();
      t_bypass();
      t_bsr();
      t_trst();
      t_exit();
      tally_and_finish();
   end
endmodule
`default_nettype wire
